// ===== verilog/otp_prog_defines.svh
`ifndef OTP_PROG_DEFINES_SVH
`define OTP_PROG_DEFINES_SVH

// Clock and pin timing, try limit, overprogram factor and entry step counts
`define CLK_PERIOD_NS 40
`define T_EDGE_NS 2000
`define T_PULSE_NS 950000
`define MAX_TRIES 25
`define OVER_FACTOR 3
`define ARRAY_STEPS 9
`define OPT_STEPS 35
`define OPT_CLK_FIRST 6
`define OPT_CLK_LAST 33

// Own register map, byte addresses
`define REG_CTRL 8'h00
`define REG_WDATA 8'h04
`define REG_STATUS 8'h08
`define REG_RDATA 8'h0c
`define REG_ADDR 8'h10

// Command codes in the control register
`define CMD_ENTER_ARRAY 4'h1
`define CMD_ENTER_OPTION 4'h2
`define CMD_CLEAR 4'h3
`define CMD_STEP 4'h4
`define CMD_PROGRAM 4'h5
`define CMD_READ 4'h6

// Status field positions
`define ST_BUSY 0
`define ST_DONE 1
`define ST_FAIL 2
`define ST_OPTION 3
`define ST_TRIES_LO 8
`define ST_TRIES_HI 12

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ===== verilog/otp_prog_pkg.sv
`default_nettype none
package otp_prog_pkg;

  typedef struct packed {
    logic mode_select;
    logic vpp;
    logic clear;
    logic clock;
    logic program_strobe_n;
    logic oe_n;
    logic ce_n;
  } pins_type;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } data_drive_type;

  typedef enum logic [3:0] {
    S_IDLE, S_ENTRY, S_STEP_HI, S_STEP_LO, S_CLR_HI, S_CLR_LO, S_SETUP, S_PULSE,
    S_RECOVER, S_OE_LOW, S_VERIFY, S_OVER_SET, S_OVER, S_FINISH
  } state_type;

endpackage : otp_prog_pkg
`default_nettype wire

// ===== verilog/otp_prog_host.sv
// How it works
// - Unprogrammed verify: pulse and verify again
// - Fail after twenty-fifth unsuccessful attempt
// - Overprogram three times accumulated pulse time
// - Revisit only by clear then clocking forward
// - Clock high then low for next location
// - Option entry: idle pins, raise supply, clear
// - Supply dip, then output enable after delays
// - Seven clock/enable cycles, then mode select
// - Option data driven before strobe falls
// - Option bits: retry, fail, overprogram alike
// - Array entry sequence with edge delays
`include "otp_prog_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module otp_prog_host #(
  parameter int unsigned PULSE_CYCLES = (`T_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int unsigned EDGE_CYCLES = (`T_EDGE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Device control pins
  output otp_prog_pkg::pins_type pins,
  // Device data port
  input wire logic [7:0] data_port_in,
  output logic [7:0] data_port_out,
  output logic [7:0] data_port_oe
);
  import otp_prog_pkg::*;

  function automatic logic [31:0] sub1(input logic [31:0] v);
    sub1 = (v == 32'h0) ? 32'h0 : v - 32'h1;
  endfunction : sub1

  // Entry pin sequence, one edge per step
  function automatic pins_type entry_pins(input logic opt, input logic [5:0] idx,
                                          input pins_type cur);
    logic [5:0] k;
    entry_pins = cur;
    k = idx - 6'(`OPT_CLK_FIRST);
    if (!opt)
    begin
      case (idx)
        6'h00: entry_pins.mode_select = 1'b0;
        6'h01: entry_pins.oe_n = 1'b0;
        6'h02: entry_pins.vpp = 1'b1;
        6'h03: entry_pins.clear = 1'b1;
        6'h04: entry_pins.clear = 1'b0;
        6'h05: entry_pins.vpp = 1'b0;
        6'h06: entry_pins.vpp = 1'b1;
        6'h07: entry_pins.oe_n = 1'b1;
        default: entry_pins.mode_select = 1'b1;
      endcase
    end
    else if (idx < 6'(`OPT_CLK_FIRST))
    begin
      case (idx)
        6'h00: entry_pins.vpp = 1'b1;
        6'h01: entry_pins.clear = 1'b1;
        6'h02: entry_pins.clear = 1'b0;
        6'h03: entry_pins.vpp = 1'b0;
        6'h04: entry_pins.vpp = 1'b1;
        default: entry_pins.oe_n = 1'b1;
      endcase
    end
    else if (idx <= 6'(`OPT_CLK_LAST))
    begin
      case (k[1:0])
        2'h0: entry_pins.clock = 1'b1;
        2'h1: entry_pins.oe_n = 1'b0;
        2'h2: entry_pins.oe_n = 1'b1;
        default: entry_pins.clock = 1'b0;
      endcase
    end
    else
      entry_pins.mode_select = 1'b1;
  endfunction : entry_pins

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus
  logic aw_q, aw_d, w_q, w_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [7:0] target_q, target_d;
  logic wr_go, cmd_go;
  logic [3:0] cmd;

  state_type state_q, state_d;
  logic done_q, done_d, fail_q, fail_d, option_q, option_d;
  logic [4:0] tries_q, tries_d;
  logic [7:0] read_q, read_d;
  logic [15:0] addr_q, addr_d;

  assign s_axi_awready = !aw_q;
  assign s_axi_wready = !w_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign wr_go = aw_q && w_q && !bvalid_q;
  assign cmd = wdata_q[3:0];
  // Commands while busy are dropped; software polls the busy bit first
  assign cmd_go = wr_go && awaddr_q == `REG_CTRL && wdata_q[0 +: 4] != 4'h0 &&
                  state_q == S_IDLE;

  always_comb
  begin
    aw_d = aw_q;
    w_d = w_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    bvalid_d = bvalid_q && !s_axi_bready;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q && !s_axi_rready;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    target_d = target_q;
    if (s_axi_awvalid && !aw_q)
    begin
      aw_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_q)
    begin
      w_d = 1'b1;
      wdata_d = s_axi_wdata;
    end
    if (wr_go)
    begin
      aw_d = 1'b0;
      w_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = `RESP_OKAY;
      case (awaddr_q)
        `REG_CTRL: ;
        `REG_WDATA: target_d = wdata_q[7:0];
        default: bresp_d = `RESP_SLVERR;
      endcase
    end
    if (s_axi_arvalid && !rvalid_q)
    begin
      rvalid_d = 1'b1;
      rresp_d = `RESP_OKAY;
      rdata_d = 32'h0;
      case (s_axi_araddr)
        `REG_CTRL: rdata_d = 32'h0;
        `REG_WDATA: rdata_d[7:0] = target_q;
        `REG_STATUS:
        begin
          rdata_d[`ST_BUSY] = state_q != S_IDLE;
          rdata_d[`ST_DONE] = done_q;
          rdata_d[`ST_FAIL] = fail_q;
          rdata_d[`ST_OPTION] = option_q;
          rdata_d[`ST_TRIES_HI:`ST_TRIES_LO] = tries_q;
        end
        `REG_RDATA: rdata_d[7:0] = read_q;
        `REG_ADDR: rdata_d[15:0] = addr_q;
        default: rresp_d = `RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= 2'h0;
      target_q <= 8'hff;
    end
    else
    begin
      aw_q <= aw_d;
      w_q <= w_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      target_q <= target_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin sequencer
  pins_type pins_q, pins_d;
  data_drive_type drv_q, drv_d;
  logic [31:0] cnt_q, cnt_d;
  logic [7:0] units_q, units_d;
  logic [5:0] idx_q, idx_d;

  assign pins = pins_q;
  assign data_port_out = drv_q.out;
  assign data_port_oe = drv_q.oe;

  always_comb
  begin
    state_d = state_q;
    pins_d = pins_q;
    drv_d = drv_q;
    cnt_d = sub1(cnt_q);
    units_d = units_q;
    idx_d = idx_q;
    done_d = done_q;
    fail_d = fail_q;
    option_d = option_q;
    tries_d = tries_q;
    read_d = read_q;
    addr_d = addr_q;
    pins_d.ce_n = 1'b0;
    if (state_q == S_IDLE)
    begin
      if (cmd_go)
      begin
        done_d = 1'b0;
        fail_d = 1'b0;
        cnt_d = EDGE_CYCLES;
        case (cmd)
          `CMD_ENTER_ARRAY, `CMD_ENTER_OPTION:
          begin
            option_d = cmd == `CMD_ENTER_OPTION;
            idx_d = 6'h00;
            drv_d.oe = 8'h00;
            pins_d.vpp = 1'b0;
            pins_d.clear = 1'b0;
            pins_d.clock = 1'b0;
            pins_d.program_strobe_n = 1'b1;
            pins_d.oe_n = 1'b1;
            pins_d.mode_select = cmd == `CMD_ENTER_ARRAY;
            addr_d = 16'h0;
            state_d = S_ENTRY;
          end
          `CMD_CLEAR:
          begin
            pins_d.clear = 1'b1;
            addr_d = 16'h0;
            state_d = S_CLR_HI;
          end
          `CMD_STEP:
          begin
            pins_d.clock = 1'b1;
            addr_d = addr_q + 16'h1;
            state_d = S_STEP_HI;
          end
          `CMD_PROGRAM:
          begin
            tries_d = 5'h0;
            drv_d.out = target_q;
            drv_d.oe = 8'hff;
            state_d = S_SETUP;
          end
          `CMD_READ:
          begin
            pins_d.oe_n = 1'b0;
            // Stale tries would send a plain read into verify
            tries_d = 5'h0;
            state_d = S_OE_LOW;
          end
          default: done_d = 1'b1;
        endcase
      end
    end
    else if (cnt_q == 32'h0)
    begin
      cnt_d = EDGE_CYCLES;
      case (state_q)
        S_ENTRY:
        begin
          pins_d = entry_pins(option_q, idx_q, pins_q);
          idx_d = idx_q + 6'h1;
          if (idx_q == (option_q ? 6'(`OPT_STEPS - 1) : 6'(`ARRAY_STEPS - 1)))
            state_d = S_FINISH;
        end
        S_STEP_HI:
        begin
          pins_d.clock = 1'b0;
          state_d = S_FINISH;
        end
        S_CLR_HI:
        begin
          pins_d.clear = 1'b0;
          state_d = S_FINISH;
        end
        S_SETUP:
        begin
          pins_d.program_strobe_n = 1'b0;
          cnt_d = PULSE_CYCLES;
          state_d = S_PULSE;
        end
        S_PULSE:
        begin
          pins_d.program_strobe_n = 1'b1;
          tries_d = tries_q + 5'h1;
          state_d = S_RECOVER;
        end
        S_RECOVER:
        begin
          drv_d.oe = 8'h00;
          pins_d.oe_n = 1'b0;
          state_d = S_OE_LOW;
        end
        S_OE_LOW:
        begin
          read_d = data_port_in;
          pins_d.oe_n = 1'b1;
          state_d = (tries_q == 5'h0) ? S_FINISH : S_VERIFY;
        end
        S_VERIFY:
        begin
          if (read_q == target_q)
          begin
            drv_d.oe = 8'hff;
            state_d = S_OVER_SET;
          end
          else if (tries_q == 5'(`MAX_TRIES))
          begin
            fail_d = 1'b1;
            state_d = S_FINISH;
          end
          else
          begin
            drv_d.oe = 8'hff;
            state_d = S_SETUP;
          end
        end
        S_OVER_SET:
        begin
          pins_d.program_strobe_n = 1'b0;
          units_d = 8'(`OVER_FACTOR) * 8'(tries_q);
          cnt_d = PULSE_CYCLES;
          state_d = S_OVER;
        end
        S_OVER:
        begin
          // Pulse units run back to back with the strobe held low
          if (units_q > 8'h1)
          begin
            units_d = units_q - 8'h1;
            cnt_d = PULSE_CYCLES;
          end
          else
          begin
            pins_d.program_strobe_n = 1'b1;
            drv_d.oe = 8'h00;
            state_d = S_FINISH;
          end
        end
        default:
        begin
          done_d = 1'b1;
          cnt_d = 32'h0;
          state_d = S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= S_IDLE;
      pins_q <= '{mode_select: 1'b0, vpp: 1'b0, clear: 1'b0, clock: 1'b0,
                  program_strobe_n: 1'b1, oe_n: 1'b1, ce_n: 1'b0};
      drv_q <= '{out: 8'h00, oe: 8'h00};
      cnt_q <= 32'h0;
      units_q <= 8'h00;
      idx_q <= 6'h00;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      option_q <= 1'b0;
      tries_q <= 5'h0;
      read_q <= 8'h00;
      addr_q <= 16'h0;
    end
    else
    begin
      state_q <= state_d;
      pins_q <= pins_d;
      drv_q <= drv_d;
      cnt_q <= cnt_d;
      units_q <= units_d;
      idx_q <= idx_d;
      done_q <= done_d;
      fail_q <= fail_d;
      option_q <= option_d;
      tries_q <= tries_d;
      read_q <= read_d;
      addr_q <= addr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_clear_zero;
    @(posedge aclk) disable iff (!aresetn)
      $rose(pins_q.clear) && state_q == S_CLR_HI |-> addr_q == 16'h0;
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("clear left address nonzero");

  property p_step_count;
    @(posedge aclk) disable iff (!aresetn)
      $rose(pins_q.clock) && state_q == S_STEP_HI |-> addr_q == $past(addr_q) + 16'h1;
  endproperty
  a_step_count: assert property (p_step_count) else $error("address did not advance");

  property p_strobe_data;
    @(posedge aclk) disable iff (!aresetn)
      !pins_q.program_strobe_n |-> drv_q.oe == 8'hff && drv_q.out == target_q && pins_q.oe_n;
  endproperty
  a_strobe_data: assert property (p_strobe_data) else $error("strobe low without data");

  property p_no_contention;
    @(posedge aclk) disable iff (!aresetn)
      !pins_q.oe_n |-> drv_q.oe == 8'h00;
  endproperty
  a_no_contention: assert property (p_no_contention) else $error("port driven during read");

  property p_sample;
    @(posedge aclk) disable iff (!aresetn)
      state_q == S_OE_LOW && cnt_q == 32'h0 |=> read_q == $past(data_port_in) && pins_q.oe_n;
  endproperty
  a_sample: assert property (p_sample) else $error("read byte not captured");

  property p_retry;
    @(posedge aclk) disable iff (!aresetn)
      state_q == S_VERIFY && cnt_q == 32'h0 && read_q != target_q &&
      tries_q < 5'(`MAX_TRIES) |=> state_q == S_SETUP ##1 state_q == S_SETUP;
  endproperty
  a_retry: assert property (p_retry) else $error("no retry after failed verify");

  property p_fail;
    @(posedge aclk) disable iff (!aresetn)
      state_q == S_VERIFY && cnt_q == 32'h0 && read_q != target_q &&
      tries_q == 5'(`MAX_TRIES) |=> fail_q && pins_q.program_strobe_n;
  endproperty
  a_fail: assert property (p_fail) else $error("no failure at try limit");

  property p_tries_bound;
    @(posedge aclk) disable iff (!aresetn)
      tries_q <= 5'(`MAX_TRIES);
  endproperty
  a_tries_bound: assert property (p_tries_bound) else $error("too many attempts");

  property p_over;
    @(posedge aclk) disable iff (!aresetn)
      state_q == S_OVER_SET && cnt_q == 32'h0 |=>
      !pins_q.program_strobe_n && units_q == 8'(`OVER_FACTOR) * 8'(tries_q);
  endproperty
  a_over: assert property (p_over) else $error("overprogram length wrong");

  property p_mode_last;
    @(posedge aclk) disable iff (!aresetn)
      state_q == S_FINISH && option_q && $rose(pins_q.mode_select) |->
      pins_q.vpp && pins_q.oe_n && !pins_q.clock;
  endproperty
  a_mode_last: assert property (p_mode_last) else $error("mode select raised early");

endmodule : otp_prog_host
`default_nettype wire

// ===== tb/otp_device_model.sv
`timescale 1ns/1ns
`default_nettype none
module otp_device_model (
  // Control pins from the programmer
  input wire otp_prog_pkg::pins_type pins,
  // Data port
  input wire logic [7:0] host_out,
  input wire logic [7:0] host_oe,
  output logic [7:0] port_level,
  // Slow cells: pulse from which bits take
  input wire logic [4:0] pulses_needed
);
  import otp_prog_pkg::*;
  logic [7:0] mem [16];
  logic [7:0] option_byte;
  logic [7:0] latch_q;
  logic [7:0] dev_val;
  logic option_mode;
  logic dev_on;
  logic [15:0] address;
  logic [4:0] tries;
  logic [3:0] clk_rises;

  initial
  begin
    foreach (mem[i]) mem[i] = 8'hff;
    option_byte = 8'hff;
    option_mode = 1'b0;
    address = 16'h0000;
    tries = 5'h00;
    clk_rises = 4'h0;
  end

  ////////////////////////////////////////////////////////////////
  // Clear, clock and the strobe's rising edge act only with supply up, so power-up unknowns are ignored
  always @(posedge pins.clear)
  begin
    if (pins.vpp === 1'b1)
    begin
      address = 16'h0000;
      tries = 5'h00;
      clk_rises = 4'h0;
    end
  end

  always @(posedge pins.clock)
  begin
    if (pins.vpp === 1'b1)
    begin
      address = address + 16'h0001;
      tries = 5'h00;
      if (pins.mode_select === 1'b0)
        clk_rises = clk_rises + 4'h1;
    end
  end

  always @(posedge pins.mode_select)
    option_mode = (clk_rises == 4'h7);

  always @(negedge pins.program_strobe_n)
    latch_q = port_level;

  // Cells only go from one to zero
  always @(posedge pins.program_strobe_n)
  begin
    if (pins.vpp === 1'b1)
    begin
      tries = tries + 5'h01;
      if (tries >= pulses_needed && option_mode)
        option_byte = (option_byte & latch_q) | 8'h28;
      else if (tries >= pulses_needed)
        mem[address[3:0]] = mem[address[3:0]] & latch_q;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Released bits flip, so a stale level never passes for data
  assign dev_on = (pins.oe_n === 1'b0) && (pins.vpp === 1'b1);
  assign dev_val = option_mode ? option_byte : mem[address[3:0]];
  always @(host_out, host_oe, dev_on, dev_val)
    for (int i = 0; i < 8; i++)
      port_level[i] = host_oe[i] ? (dev_on ? 1'bx : host_out[i])
                                 : (dev_on ? dev_val[i] : ~port_level[i]);
endmodule : otp_device_model
`default_nettype wire

// ===== tb/otp_array_and_option_programming_test.sv
`timescale 1ns/1ns
`default_nettype none
`include "otp_prog_defines.svh"
`define CHECK(what, exp, got) \
  begin \
    checks++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got); \
    end \
  end
module otp_array_and_option_programming_test;
  import otp_prog_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, clk_prev;
  logic [7:0] awaddr, araddr, port_level, host_out, host_oe;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, resp;
  logic [4:0] pulses_needed;
  pins_type pins;
  int fail_count, checks, low_cnt, clk_count;
  int pulses [$];
  logic [7:0] vals [3] = '{8'h5a, 8'h00, 8'hc3};
  logic [7:0] regs [5] = '{`REG_CTRL, `REG_WDATA, `REG_STATUS, `REG_ADDR, 8'h14};
  logic [31:0] rvals [5] = '{32'h0, 32'hff, 32'h0, 32'h0, 32'h0};
  int needs [3] = '{1, 3, 25};

  otp_prog_host #(.PULSE_CYCLES(20), .EDGE_CYCLES(3)) u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pins(pins), .data_port_in(port_level), .data_port_out(host_out), .data_port_oe(host_oe));
  otp_device_model u_dev (.pins(pins), .host_out(host_out), .host_oe(host_oe),
    .port_level(port_level), .pulses_needed(pulses_needed));

  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////
  // Strobe pulse lengths and device clock rises, in bus cycles
  always @(posedge aclk)
  begin
    clk_prev <= pins.clock;
    if (pins.clock === 1'b1 && clk_prev === 1'b0)
      clk_count++;
    if (pins.program_strobe_n === 1'b0)
      low_cnt++;
    else if (low_cnt != 0)
    begin
      pulses.push_back(low_cnt);
      low_cnt = 0;
    end
  end

  task end_of_test;
    if (fail_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test

  task hang;
    fail_count++;
    end_of_test;
  endtask : hang

  ////////////////////////////////////////////////////////////////
  task axi_write(input logic [7:0] a, input logic [31:0] d);
    int n;
    // One edge between calls, so no signal is set twice in a time step
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid)
        break;
    end
    resp = bresp;
    bready <= 1'b0;
    if (n == 100)
      hang;
  endtask : axi_write

  task axi_read(input logic [7:0] a);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
        break;
    end
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
    if (n == 100)
      hang;
  endtask : axi_read

  task command(input logic [3:0] c);
    int n;
    axi_write(`REG_CTRL, {28'h0, c});
    for (n = 0; n < 5000; n++)
    begin
      axi_read(`REG_STATUS);
      if (rd[`ST_DONE] === 1'b1 && rd[`ST_BUSY] === 1'b0)
        break;
    end
    if (n == 5000)
      hang;
  endtask : command

  // Cells take from pulse n on; n above 25 never takes
  task prog(input logic [7:0] v, input logic [4:0] n);
    int t;
    axi_write(`REG_WDATA, {24'h0, v});
    pulses_needed <= n;
    pulses.delete();
    t = (n > 5'h19) ? 25 : int'(n);
    command(`CMD_PROGRAM);
    axi_read(`REG_STATUS);
    `CHECK("tries", 5'(t), rd[`ST_TRIES_HI:`ST_TRIES_LO])
    `CHECK("fail", (n > 5'h19), rd[`ST_FAIL])
    `CHECK("pulse count", t + ((n > 5'h19) ? 0 : 1), pulses.size())
    for (int k = 0; k < pulses.size(); k++)
      `CHECK("pulse length", (k < t) ? 21 : 63 * t, pulses[k])
  endtask : prog

  ////////////////////////////////////////////////////////////////
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, clk_prev} = 7'h00;
    {awaddr, araddr, wdata} = 48'h0;
    pulses_needed = 5'h01;
    fail_count = 0;
    checks = 0;
    low_cnt = 0;
    clk_count = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    `CHECK("strobe idle", 1'b1, pins.program_strobe_n)
    `CHECK("port released", 8'h00, host_oe)
    `CHECK("chip enable", 1'b0, pins.ce_n)
    for (int i = 0; i < 5; i++)
    begin
      axi_read(regs[i]);
      `CHECK("reset value", rvals[i], rd)
      `CHECK("read resp", (i == 4) ? `RESP_SLVERR : `RESP_OKAY, resp)
    end
    axi_write(8'h18, 32'h0);
    `CHECK("unmapped write", `RESP_SLVERR, resp)
    command(`CMD_ENTER_ARRAY);
    `CHECK("array entry clocks", 0, clk_count)
    `CHECK("array mode", 1'b0, u_dev.option_mode)
    for (int i = 0; i < 3; i++)
    begin
      prog(vals[i], 5'(needs[i]));
      `CHECK("cell", vals[i], u_dev.mem[i])
      command(`CMD_STEP);
      axi_read(`REG_ADDR);
      `CHECK("address", 32'(i + 1), rd)
      `CHECK("device address", 16'(i + 1), u_dev.address)
    end
    prog(8'h0f, 5'h1a);
    `CHECK("failed cell", 8'hff, u_dev.mem[3])
    command(`CMD_CLEAR);
    `CHECK("cleared address", 16'h0000, u_dev.address)
    command(`CMD_STEP);
    command(`CMD_READ);
    axi_read(`REG_RDATA);
    `CHECK("read back", {24'h0, vals[1]}, rd)
    // A plain read after a failed program must not verify again
    axi_read(`REG_STATUS);
    `CHECK("read no fail", 1'b0, rd[`ST_FAIL])
    clk_count = 0;
    command(`CMD_ENTER_OPTION);
    `CHECK("option entry clocks", 7, clk_count)
    `CHECK("option mode", 1'b1, u_dev.option_mode)
    axi_read(`REG_STATUS);
    `CHECK("option flag", 1'b1, rd[`ST_OPTION])
    command(`CMD_STEP);
    prog(8'h3a, 5'h02);
    `CHECK("option byte", 8'h3a, u_dev.option_byte)
    command(`CMD_STEP);
    command(`CMD_READ);
    axi_read(`REG_RDATA);
    `CHECK("option read", 32'h3a, rd)
    `CHECK("read pulses", 3, pulses.size())
    end_of_test;
  end
endmodule : otp_array_and_option_programming_test
`default_nettype wire
